// *** hdl/amp_ctrl_pkg.sv ***
// Shared constants and types for the amplifier gain control core
package amp_ctrl_pkg;
    localparam int unsigned STEP_W       = 5;
    localparam logic [4:0]  STEP_MUTE    = 5'h00;
    localparam logic [4:0]  STEP_MAX     = 5'h1f;
    // Synchroniser reset: bridged, line inputs, fade-on, awake
    localparam logic [4:0]  PIN_IDLE     = 5'h02;
    // Gain in dB of step 1 per mode, step pitch 2 dB
    localparam int          BTL_LOW_DB   = -40;
    localparam int          SE_LOW_DB    = -46;
    localparam int          MUTE_DB      = -85;
    localparam int          STEP_DB      = 2;
    // Ramp clock: 58 Hz nominal, two ticks per gain step
    localparam int unsigned CLK_HZ       = 50000000;
    localparam int unsigned RAMP_HZ      = 58;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / RAMP_HZ;
    localparam int unsigned TICKS_PER_STEP = 2;
    localparam int unsigned TICK_W       = 20;

    typedef enum logic [2:0] {
        ST_POWERUP  = 3'b000,
        ST_ACTIVE   = 3'b001,
        ST_FADE_DN  = 3'b010,
        ST_DISCHG   = 3'b011,
        ST_SLEEP    = 3'b100,
        ST_CHARGE   = 3'b101,
        ST_FADE_UP  = 3'b110
    } seq_state_t;

    typedef struct packed {
        logic [4:0] main_level;
        logic [4:0] headphone_offset_level;
        logic [4:0] headphone_ceiling_level;
    } level_in_t;

    typedef struct packed {
        logic       neg_follower_on;
        logic       single_ended_drive;
        logic       alt_input_sel;
        logic       ref_charge;
        logic       outputs_muted;
        logic       low_current;
    } drive_out_t;
endpackage : amp_ctrl_pkg

// *** hdl/ramp_tick.sv ***
// Slow ramp clock tick generator
`timescale 1ns/10ps
`default_nettype none
module ramp_tick #(
    parameter int unsigned TICK_CYCLES = amp_ctrl_pkg::TICK_CYCLES
) (
    input  wire logic clock,
    input  wire logic reset,
    output logic      tick
);
    logic [amp_ctrl_pkg::TICK_W-1:0] cnt_ff;
    logic [amp_ctrl_pkg::TICK_W-1:0] nxt_cnt;
    logic                            nxt_tick;
    logic                            tick_ff;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff + 1'b1;
        if (cnt_ff == amp_ctrl_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule : ramp_tick
`default_nettype wire

// *** hdl/level_hyst.sv ***
// Direction-dependent hysteresis on a quantized level index
`timescale 1ns/10ps
`default_nettype none
module level_hyst (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [4:0] rising_idx,
    input  wire logic [4:0] falling_idx,
    output logic [4:0]      level
);
    logic [4:0] level_ff;
    logic [4:0] nxt_level;

    // Rising index uses the upper trip points, falling the lower ones;
    // a value inside the gap keeps the held step, so no oscillation.
    always_comb begin
        nxt_level = level_ff;
        if (rising_idx > level_ff)
            nxt_level = rising_idx;
        else if (falling_idx < level_ff)
            nxt_level = falling_idx;
    end

    always_ff @(posedge clock) begin
        if (reset)
            level_ff <= 5'h00;
        else
            level_ff <= nxt_level;
    end

    assign level = level_ff;
endmodule : level_hyst
`default_nettype wire

// *** hdl/amp_gain_step_fade_control.sv ***
// Gain step, input/output select and fade sequencing core
// What this block does
// - Speaker mode: 31 steps, mute, -40..20 dB
// - Headphone mode: mute, -46..14 dB steps
// - Config low keeps negative followers on, except in discharge and sleep
// - Source select high routes alternate inputs
// - Ramp select low means fade-on mode
// - Fade-on sleep: step down every two ticks
// - Ramp-down length follows held gain, 31 max
// - Discharge reference only after gain bottom
// - Fade-on wake: charge, then step gain up
// - Fade-off sleep: save gain, drop, discharge
// - Fade-off wake: charge, restore saved gain
// - Power-up ramps from lowest gain upward
// - Sleep request low mutes, low current
// - Hysteresis keeps step selection from oscillating
// - Headphone level is main minus offset
// - Headphone gain capped by ceiling level
`timescale 1ns/10ps
`default_nettype none
module amp_gain_step_fade_control #(
    parameter int unsigned TICK_CYCLES = amp_ctrl_pkg::TICK_CYCLES
) (
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire amp_ctrl_pkg::level_in_t level_rise,
    input  wire amp_ctrl_pkg::level_in_t level_fall,
    input  wire logic                    output_config_select,
    input  wire logic                    input_source_select,
    input  wire logic                    ramp_mode_select,
    input  wire logic                    sleep_request_n,
    input  wire logic                    ref_settled,
    output amp_ctrl_pkg::drive_out_t     drive,
    output logic [4:0]                   gain_step,
    output logic signed [7:0]            gain_db,
    output logic                         ramping
);
    // Pin synchronisers
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;
    logic [4:0] nxt_pin_meta;
    logic [4:0] nxt_pin_sync;
    logic       cfg_se;
    logic       src_alt;
    logic       fade_off;
    logic       awake;
    logic       ref_ok;

    always_comb begin
        nxt_pin_meta = {output_config_select, input_source_select,
                        ramp_mode_select, sleep_request_n, ref_settled};
        nxt_pin_sync = pin_meta_ff;
    end

    always_ff @(posedge clock) begin
        // Idle levels, else a false sleep follows every reset
        if (reset) begin
            pin_meta_ff <= amp_ctrl_pkg::PIN_IDLE;
            pin_sync_ff <= amp_ctrl_pkg::PIN_IDLE;
        end else begin
            pin_meta_ff <= nxt_pin_meta;
            pin_sync_ff <= nxt_pin_sync;
        end
    end

    assign cfg_se   = pin_sync_ff[4];
    assign src_alt  = pin_sync_ff[3];
    assign fade_off = pin_sync_ff[2];
    assign awake    = pin_sync_ff[1];
    assign ref_ok   = pin_sync_ff[0];

    // Level indices; comparator outputs already quantized
    logic [4:0] main_lvl;
    logic [4:0] offs_lvl;
    logic [4:0] ceil_lvl;
    logic       tick;

    level_hyst u_main_hyst (
        .clock       (clock),
        .reset       (reset),
        .rising_idx  (level_rise.main_level),
        .falling_idx (level_fall.main_level),
        .level       (main_lvl)
    );

    level_hyst u_offs_hyst (
        .clock       (clock),
        .reset       (reset),
        .rising_idx  (level_rise.headphone_offset_level),
        .falling_idx (level_fall.headphone_offset_level),
        .level       (offs_lvl)
    );

    level_hyst u_ceil_hyst (
        .clock       (clock),
        .reset       (reset),
        .rising_idx  (level_rise.headphone_ceiling_level),
        .falling_idx (level_fall.headphone_ceiling_level),
        .level       (ceil_lvl)
    );

    ramp_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .reset (reset),
        .tick  (tick)
    );

    // Headphone step: difference, floored at mute, then capped
    function automatic logic [4:0] headphone_level(
        input logic [4:0] lvl,
        input logic [4:0] offs,
        input logic [4:0] ceil_l
    );
        logic [4:0] diff;
        diff = (lvl > offs) ? 5'(lvl - offs) : amp_ctrl_pkg::STEP_MUTE;
        return (diff > ceil_l) ? ceil_l : diff;
    endfunction : headphone_level

    // Step index to dB; index 0 is mute
    function automatic logic signed [7:0] step_to_db(
        input logic [4:0] step,
        input logic       se
    );
        int base;
        base = se ? amp_ctrl_pkg::SE_LOW_DB : amp_ctrl_pkg::BTL_LOW_DB;
        if (step == amp_ctrl_pkg::STEP_MUTE)
            return 8'(amp_ctrl_pkg::MUTE_DB);
        return 8'(base + amp_ctrl_pkg::STEP_DB * (int'(step) - 1));
    endfunction : step_to_db

    logic [4:0] target;

    always_comb begin
        if (cfg_se)
            target = headphone_level(main_lvl, offs_lvl, ceil_lvl);
        else
            target = main_lvl;
    end

    // Gain sequencer
    amp_ctrl_pkg::seq_state_t state_ff;
    amp_ctrl_pkg::seq_state_t nxt_state;
    logic [4:0] gain_ff;
    logic [4:0] nxt_gain;
    logic [4:0] saved_ff;
    logic [4:0] nxt_saved;
    logic       half_ff;
    logic       nxt_half;
    logic       charge_ff;
    logic       nxt_charge;
    logic       step_now;

    // Two ticks per step; the half flag marks the first tick
    assign step_now = tick & half_ff;

    always_comb begin
        nxt_state  = state_ff;
        nxt_gain   = gain_ff;
        nxt_saved  = saved_ff;
        nxt_charge = charge_ff;
        nxt_half   = tick ? ~half_ff : half_ff;
        case (state_ff)
            amp_ctrl_pkg::ST_POWERUP: begin
                // Ramp regardless of the mode pin; a sleep mid-ramp
                // follows the mode pin like any other shutdown
                nxt_charge = 1'b1;
                if (!awake) begin
                    if (fade_off) begin
                        nxt_saved  = gain_ff;
                        nxt_gain   = amp_ctrl_pkg::STEP_MUTE;
                        nxt_charge = 1'b0;
                        nxt_state  = amp_ctrl_pkg::ST_DISCHG;
                    end else begin
                        nxt_half  = 1'b0;
                        nxt_state = amp_ctrl_pkg::ST_FADE_DN;
                    end
                end else if (step_now) begin
                    // Decide on a step only: target settles after reset
                    if (gain_ff >= target) begin
                        nxt_gain  = target;
                        nxt_state = amp_ctrl_pkg::ST_ACTIVE;
                    end else begin
                        nxt_gain = gain_ff + 5'h01;
                    end
                end
            end
            amp_ctrl_pkg::ST_ACTIVE: begin
                nxt_gain = target;
                if (!awake) begin
                    if (fade_off) begin
                        nxt_saved  = gain_ff;
                        nxt_gain   = amp_ctrl_pkg::STEP_MUTE;
                        nxt_charge = 1'b0;
                        nxt_state  = amp_ctrl_pkg::ST_DISCHG;
                    end else begin
                        nxt_half  = 1'b0;
                        nxt_state = amp_ctrl_pkg::ST_FADE_DN;
                    end
                end
            end
            amp_ctrl_pkg::ST_FADE_DN: begin
                // Length depends on the starting step, 31 from the top
                if (gain_ff == amp_ctrl_pkg::STEP_MUTE) begin
                    nxt_charge = 1'b0;
                    nxt_state  = amp_ctrl_pkg::ST_DISCHG;
                end else if (awake) begin
                    nxt_state = amp_ctrl_pkg::ST_FADE_UP;
                end else if (step_now) begin
                    nxt_gain = gain_ff - 5'h01;
                end
            end
            amp_ctrl_pkg::ST_DISCHG: begin
                nxt_charge = 1'b0;
                if (awake) begin
                    nxt_charge = 1'b1;
                    nxt_state  = amp_ctrl_pkg::ST_CHARGE;
                end else if (!ref_ok) begin
                    nxt_state = amp_ctrl_pkg::ST_SLEEP;
                end
            end
            amp_ctrl_pkg::ST_SLEEP: begin
                nxt_gain = amp_ctrl_pkg::STEP_MUTE;
                if (awake) begin
                    nxt_charge = 1'b1;
                    nxt_state  = amp_ctrl_pkg::ST_CHARGE;
                end
            end
            amp_ctrl_pkg::ST_CHARGE: begin
                // Gain held at mute until the reference is at mid-supply
                if (!awake) begin
                    nxt_charge = 1'b0;
                    nxt_state  = amp_ctrl_pkg::ST_DISCHG;
                end else if (ref_ok) begin
                    if (fade_off) begin
                        nxt_gain  = saved_ff;
                        nxt_state = amp_ctrl_pkg::ST_ACTIVE;
                    end else begin
                        nxt_half  = 1'b0;
                        nxt_state = amp_ctrl_pkg::ST_FADE_UP;
                    end
                end
            end
            amp_ctrl_pkg::ST_FADE_UP: begin
                if (!awake) begin
                    nxt_half  = 1'b0;
                    nxt_state = amp_ctrl_pkg::ST_FADE_DN;
                end else if (gain_ff >= target) begin
                    nxt_gain  = target;
                    nxt_state = amp_ctrl_pkg::ST_ACTIVE;
                end else if (step_now) begin
                    nxt_gain = gain_ff + 5'h01;
                end
            end
            default: begin
                nxt_state = amp_ctrl_pkg::ST_POWERUP;
                nxt_gain  = amp_ctrl_pkg::STEP_MUTE;
            end
        endcase
    end

    // Reset stands in for power-up: lowest gain, ramp state
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff  <= amp_ctrl_pkg::ST_POWERUP;
            gain_ff   <= amp_ctrl_pkg::STEP_MUTE;
            saved_ff  <= amp_ctrl_pkg::STEP_MUTE;
            half_ff   <= 1'b0;
            charge_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            gain_ff   <= nxt_gain;
            saved_ff  <= nxt_saved;
            half_ff   <= nxt_half;
            charge_ff <= nxt_charge;
        end
    end

    // Registered outputs
    amp_ctrl_pkg::drive_out_t drive_ff;
    amp_ctrl_pkg::drive_out_t nxt_drive;
    logic signed [7:0]        db_ff;
    logic signed [7:0]        nxt_db;
    logic                     asleep;

    assign asleep = (state_ff == amp_ctrl_pkg::ST_DISCHG) ||
                    (state_ff == amp_ctrl_pkg::ST_SLEEP);

    always_comb begin
        nxt_drive.neg_follower_on    = ~cfg_se & ~asleep;
        nxt_drive.single_ended_drive = cfg_se;
        nxt_drive.alt_input_sel      = src_alt;
        nxt_drive.ref_charge         = nxt_charge;
        nxt_drive.outputs_muted      = asleep |
            (nxt_gain == amp_ctrl_pkg::STEP_MUTE);
        nxt_drive.low_current        = (nxt_state ==
            amp_ctrl_pkg::ST_SLEEP);
        nxt_db = step_to_db(nxt_gain, cfg_se);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            drive_ff <= '0;
            db_ff    <= 8'(amp_ctrl_pkg::MUTE_DB);
        end else begin
            drive_ff <= nxt_drive;
            db_ff    <= nxt_db;
        end
    end

    assign drive     = drive_ff;
    assign gain_step = gain_ff;
    assign gain_db   = db_ff;
    assign ramping   = (state_ff == amp_ctrl_pkg::ST_POWERUP) ||
                       (state_ff == amp_ctrl_pkg::ST_FADE_DN) ||
                       (state_ff == amp_ctrl_pkg::ST_FADE_UP);
endmodule : amp_gain_step_fade_control
`default_nettype wire

// *** sim/ref_model.sv ***
// Reference capacitor model answering the charge request
`timescale 1ns/10ps
`default_nettype none
module ref_model #(
    parameter int DELAY = 4
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic ref_charge,
    output logic      ref_settled
);
    int cnt;
    // Settles only after a steady request, as a real cap would
    always @(posedge clock) begin
        if (reset || ref_charge === ref_settled) begin
            cnt <= 0;
            if (reset)
                ref_settled <= 1'b0;
        end else if (cnt == DELAY - 1) begin
            cnt <= 0;
            ref_settled <= ref_charge;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : ref_model
`default_nettype wire

// *** sim/amp_gain_monitor.sv ***
// Checker for the gain step and fade core
`timescale 1ns/10ps
`default_nettype none
module amp_gain_monitor #(
    parameter int unsigned TICK_CYCLES = 8
) (
    input wire logic                     clock,
    input wire logic                     reset,
    input wire logic                     output_config_select,
    input wire logic                     input_source_select,
    input wire logic                     ramp_mode_select,
    input wire logic                     sleep_request_n,
    input wire logic                     ref_settled,
    input wire amp_ctrl_pkg::drive_out_t drive,
    input wire logic [4:0]               gain_step,
    input wire logic signed [7:0]        gain_db,
    input wire logic                     ramping
);
    localparam int GAP = 2 * TICK_CYCLES - 1;
    logic [15:0] gap_ff;
    logic        slept_ff;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Spacing only means something within one ramp run
    always_ff @(posedge clock) begin
        if (reset || !ramping)
            gap_ff <= 16'hffff;
        else if ($changed(gain_step))
            gap_ff <= 16'h0000;
        else if (gap_ff != 16'hffff)
            gap_ff <= gap_ff + 16'h0001;
    end
    // Power-up ramp ignores the reference, so wake checks wait
    always_ff @(posedge clock) begin
        if (reset)
            slept_ff <= 1'b0;
        else if (drive.low_current)
            slept_ff <= 1'b1;
    end
    sequence pins_steady;
        ($stable(output_config_select) && $stable(input_source_select)
            && sleep_request_n && !ramping && drive.ref_charge)[*6];
    endsequence
    sequence mode_held(se);
        (drive.single_ended_drive == se)[*3];
    endsequence
    a_bridged_drive: assert property (
        pins_steady |-> drive.neg_follower_on == !output_config_select
        && drive.single_ended_drive == output_config_select)
        else $error("output drive config wrong");
    a_input_route: assert property (
        pins_steady |-> drive.alt_input_sel == input_source_select)
        else $error("input route wrong");
    // The dB word registers on the same edge as the step
    a_speaker_db: assert property (
        mode_held(1'b0) ##0 gain_step != 5'h00 |-> int'(gain_db) ==
        amp_ctrl_pkg::BTL_LOW_DB
        + amp_ctrl_pkg::STEP_DB * (int'(gain_step) - 1))
        else $error("speaker gain dB wrong");
    a_headphone_db: assert property (
        mode_held(1'b1) ##0 gain_step != 5'h00 |-> int'(gain_db) ==
        amp_ctrl_pkg::SE_LOW_DB
        + amp_ctrl_pkg::STEP_DB * (int'(gain_step) - 1))
        else $error("headphone gain dB wrong");
    a_mute_db: assert property (
        gain_step == 5'h00 |-> int'(gain_db) == amp_ctrl_pkg::MUTE_DB)
        else $error("mute dB wrong");
    a_step_unit: assert property (
        ramping && $past(ramping) |->
        int'(gain_step) - int'($past(gain_step)) inside {-1, 0, 1})
        else $error("ramp jumped more than one step");
    a_step_spacing: assert property (
        ramping && $past(ramping) && $changed(gain_step) |->
        gap_ff == 16'hffff || gap_ff == 16'(GAP))
        else $error("ramp step spacing wrong");
    a_ref_order: assert property (
        !ramp_mode_select && $fell(drive.ref_charge) |->
        gain_step == 5'h00)
        else $error("discharge before gain bottom");
    a_wake_order: assert property (
        slept_ff && $past(gain_step) == 5'h00 && gain_step != 5'h00 |->
        $past(ref_settled, 3))
        else $error("gain rose before reference settled");
    a_sleep_quiet: assert property (
        drive.low_current |-> drive.outputs_muted && !drive.ref_charge)
        else $error("low current state not muted");
endmodule : amp_gain_monitor
bind amp_gain_step_fade_control amp_gain_monitor #(
    .TICK_CYCLES(TICK_CYCLES)
) amp_gain_monitor_inst (
    .clock(clock), .reset(reset),
    .output_config_select(output_config_select),
    .input_source_select(input_source_select),
    .ramp_mode_select(ramp_mode_select),
    .sleep_request_n(sleep_request_n), .ref_settled(ref_settled),
    .drive(drive), .gain_step(gain_step), .gain_db(gain_db),
    .ramping(ramping)
);
`default_nettype wire

// *** sim/amp_gain_step_fade_control_tb.sv ***
// Self-checking bench for the gain step and fade core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module amp_gain_step_fade_control_tb;
    localparam int T = 8;
    logic                     clock;
    logic                     reset;
    amp_ctrl_pkg::level_in_t  lr;
    amp_ctrl_pkg::level_in_t  lf;
    logic                     cfg;
    logic                     src;
    logic                     rmode;
    logic                     sleep_n;
    logic                     settled;
    amp_ctrl_pkg::drive_out_t drive;
    logic [4:0]               gain_step;
    logic signed [7:0]        gain_db;
    logic                     ramping;
    int                       n_fail;
    int                       checked;
    int                       n;
    int                       m;
    int                       base;
    amp_gain_step_fade_control #(.TICK_CYCLES(T))
        amp_gain_step_fade_control_inst (
        .clock(clock), .reset(reset), .level_rise(lr), .level_fall(lf),
        .output_config_select(cfg), .input_source_select(src),
        .ramp_mode_select(rmode), .sleep_request_n(sleep_n),
        .ref_settled(settled), .drive(drive), .gain_step(gain_step),
        .gain_db(gain_db), .ramping(ramping)
    );
    ref_model #(.DELAY(4)) ref_model_inst (
        .clock(clock), .reset(reset),
        .ref_charge(drive.ref_charge), .ref_settled(settled)
    );
    function automatic logic [7:0] db_of(input int base, input int step);
        return (step == 0) ? 8'(amp_ctrl_pkg::MUTE_DB)
            : 8'(base + amp_ctrl_pkg::STEP_DB * (step - 1));
    endfunction : db_of
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic set_ctl(input logic c, s, r, q);
        @(posedge clock);
        #1;
        cfg = c;
        src = s;
        rmode = r;
        sleep_n = q;
    endtask : set_ctl
    // Pins pass a 2-ff sync, levels the hysteresis register, first
    task automatic set_lvl(input logic [4:0] r, f, o, c);
        int k;
        @(posedge clock);
        #1;
        lr = '{r, o, c};
        lf = '{f, o, c};
        k = 0;
        repeat (10) @(posedge clock);
        while (ramping !== 1'b0 && k < 2000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 2000)
            n_fail++;
        #1;
    endtask : set_lvl
    task automatic watch(input int cyc, output int cnt);
        logic [4:0] prev;
        cnt = 0;
        prev = gain_step;
        repeat (cyc) begin
            @(posedge clock);
            #1;
            if (gain_step !== prev)
                cnt++;
            prev = gain_step;
        end
    endtask : watch
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #120000;
        n_fail++;
        give_verdict();
    end
    initial begin
        n_fail = 0;
        checked = 0;
        reset = 1'b1;
        lr = '{5'h14, 5'h03, 5'h1f};
        lf = lr;
        cfg = 1'b0;
        src = 1'b0;
        rmode = 1'b0;
        sleep_n = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        watch(360, n);
        `CHK(n, 20)
        `CHK(gain_step, 5'h14)
        `CHK(gain_db, db_of(amp_ctrl_pkg::BTL_LOW_DB, 20))
        `CHK(ramping, 1'b0)
        for (int i = 0; i < 4; i++) begin
            set_ctl(i[0], i[1], 1'b0, 1'b1);
            set_lvl(5'h14, 5'h14, 5'h03, 5'h1f);
            `CHK(drive.single_ended_drive, i[0])
            `CHK(drive.neg_follower_on, !i[0])
            `CHK(drive.alt_input_sel, i[1])
            `CHK(gain_step, i[0] ? 5'h11 : 5'h14)
            base = i[0] ? amp_ctrl_pkg::SE_LOW_DB : amp_ctrl_pkg::BTL_LOW_DB;
            `CHK(gain_db, db_of(base, i[0] ? 17 : 20))
            `CHK(drive.outputs_muted, 1'b0)
        end
        set_lvl(5'h14, 5'h14, 5'h03, 5'h0a);
        `CHK(gain_step, 5'h0a)
        set_lvl(5'h14, 5'h14, 5'h19, 5'h1f);
        `CHK(gain_step, 5'h00)
        set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
        set_lvl(5'h14, 5'h14, 5'h03, 5'h1f);
        set_lvl(5'h13, 5'h14, 5'h03, 5'h1f);
        `CHK(gain_step, 5'h14)
        set_lvl(5'h12, 5'h12, 5'h03, 5'h1f);
        set_lvl(5'h12, 5'h13, 5'h03, 5'h1f);
        `CHK(gain_step, 5'h12)
        set_lvl(5'h1f, 5'h1f, 5'h00, 5'h1f);
        set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
        watch(40, n);
        `CHK(ramping, 1'b1)
        `CHK(drive.ref_charge, 1'b1)
        watch(520, m);
        `CHK(n + m, 31)
        `CHK(gain_step, 5'h00)
        `CHK(drive.ref_charge, 1'b0)
        `CHK(drive.low_current, 1'b1)
        `CHK(drive.outputs_muted, 1'b1)
        set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
        watch(560, n);
        `CHK(n, 31)
        `CHK(gain_step, 5'h1f)
        `CHK(drive.ref_charge, 1'b1)
        set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
        set_lvl(5'h0c, 5'h0c, 5'h00, 5'h1f);
        set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
        watch(40, n);
        `CHK(n, 1)
        `CHK(gain_step, 5'h00)
        `CHK(drive.ref_charge, 1'b0)
        `CHK(drive.low_current, 1'b1)
        set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
        watch(40, n);
        `CHK(n, 1)
        `CHK(gain_step, 5'h0c)
        // Second power-up, now with the fade-off mode pin high
        reset = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        `CHK(gain_step, 5'h00)
        watch(360, n);
        `CHK(n, 12)
        `CHK(gain_step, 5'h0c)
        `CHK(ramping, 1'b0)
        give_verdict();
    end
endmodule : amp_gain_step_fade_control_tb
`default_nettype wire
